// File: design/fsr_defs.svh
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// ----------------------------------------
// instruction opcodes
// ----------------------------------------
`define FSR_OP_LATCH_ON 8'h06
`define FSR_OP_LATCH_OFF 8'h04
`define FSR_OP_STAT_RD 8'h05
`define FSR_OP_STAT3_RD 8'h95
`define FSR_OP_STAT_WR 8'h01
`define FSR_OP_QPI 8'h38
`define FSR_OP_QRST 8'hff
`define FSR_OP_OTP 8'h3a
`define FSR_OP_PP 8'h02
`define FSR_OP_SE 8'h20
`define FSR_OP_HBE 8'h52
`define FSR_OP_BE 8'hd8
`define FSR_OP_CE 8'hc7
`define FSR_OP_CE2 8'h60

// ----------------------------------------
// status field positions
// ----------------------------------------
`define FSR_B_BUSY 0
`define FSR_B_LATCH 1
`define FSR_B_PROT 7
`define FSR_B_KBL 6
`define FSR_B_SIDE 5
`define FSR_B_LOCK0 7
`define FSR_B_PINOFF 6
`define FSR_B_COMPL 4
`define FSR_B_BOOT 3
`define FSR_B_LOCK1 2
`define FSR_B_LOCK2 1
`define FSR_OTP_MASK 8'hde
`define FSR_NV_MASK 8'hfc
`define FSR_SR_RESET 8'h00
`define FSR_SR3_RESET 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define FSR_CLK_NS 10
`define FSR_TW_NS 10000
`define FSR_TW_CYC ((`FSR_TW_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)

`endif

// File: design/fsr_pkg.sv
package fsr_pkg;

  // ----------------------------------------
  // link phases
  // ----------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_OPC, PH_ADDR, PH_DATA, PH_PAGE, PH_OUT, PH_DONE
  } fsr_phase_t;

  // array operation kinds
  typedef enum logic [2:0] {
    K_NONE, K_PP, K_SE, K_HBE, K_BE, K_CE
  } fsr_kind_t;

  // request to the array engine
  typedef struct packed {
    logic valid;
    fsr_kind_t kind;
    logic [23:0] addr;
  } fsr_op_t;

  // whole state of the status block
  typedef struct packed {
    fsr_phase_t phase;
    logic [7:0] opc;
    logic [4:0] cnt;
    logic [23:0] addr;
    logic [7:0] data;
    logic [7:0] shout;
    logic [3:0] dq_out;
    logic [3:0] dq_oe;
    logic extra;
    logic quad;
    logic otp;
    logic wr_latch;
    logic busy;
    logic st_wr;
    logic [15:0] tmr;
    logic [7:0] nv;
    logic [7:0] otpb;
    logic [7:0] sr3;
    fsr_op_t req;
    logic prev_sck;
    logic prev_cs_n;
  } fsr_state_t;

endpackage

// File: design/fsr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for pins from outside the clock domain
module fsr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins in, synced out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta; // first stage, read only by q

  // ----------------------------------------
  // two stages
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// File: design/fsr_core.sv
// How it works
// R1: write disable clears latch or leaves otp
// R2: host sends write disable as lone byte
// R3: latch clears at reset and op completion
// R4: status readable anytime, even while busy
// R5: status byte repeats while select stays low
// R6: host polls busy before new instruction
// R7: normal layout protect,size,side,bp,latch,busy
// R8: otp layout locks,disable,complement,boot,busy
// R9: busy high during write, program, erase
// R10: latch low refuses writes, programs, erases
// R11: programs or erases touching protection ignored; chip erase ignores complement
// R12: chip erase only with block protect zero
// R13: protect bit with wp low blocks writes
// R14: size and top/bottom select, default zero
// R15: security locks one time, block page writes
// R16: boot lock freezes size, side, region
// R17: pin disable makes wp and hold ignored
// R18: quad read and quad enable always accepted
// R19: complement inverts the protected region
// R20: third status register read repeats
// R21: quad enable makes all transfers nibble wide
// R22: write enable sets the latch
// R23: sample on rising, shift out on falling
// R24: status and opcodes msb first
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.svh"

module fsr_core #(
  parameter int ADDR_W = 21,
  parameter int TW_CYC = `FSR_TW_CYC
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // serial link pins
  input wire logic SPI_SCK,
  input wire logic SPI_CS_N,
  input wire logic [3:0] DQ_IN,
  output logic [3:0] DQ_OUT,
  output logic [3:0] DQ_OE,
  // array engine
  output fsr_pkg::fsr_op_t ARRAY_REQ,
  input wire logic ARRAY_DONE,
  // status view
  output logic [7:0] STATUS_BYTE,
  output logic QUAD_MODE
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] pins; // synced sck, inverted cs_n, dq
  logic sck; // synced serial clock
  logic cs_n; // synced select
  logic [3:0] dq; // synced data lines

  fsr_sync #(.W(6)) u_sync (
    .clk(CLK_SYS),
    .nrst(NRST),
    .d({SPI_SCK, ~SPI_CS_N, DQ_IN}),
    .q(pins)
  );

  assign sck = pins[5];
  // select is synced inverted so the flops reset to deselected
  assign cs_n = ~pins[4];
  assign dq = pins[3:0];

  fsr_pkg::fsr_state_t s; // registered state
  fsr_pkg::fsr_state_t next_s; // next state

  // ----------------------------------------
  // protection check
  // ----------------------------------------
  // true when the target range touches protected data
  function automatic logic blocked(fsr_pkg::fsr_kind_t k, logic [23:0] a,
                                   logic [7:0] n, logic [7:0] o, logic otpm);
    logic [31:0] mem;
    logic [31:0] unit;
    logic [31:0] span;
    logic [31:0] sz;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] tlo;
    logic [31:0] thi;
    logic [31:0] blo;
    logic hit;
    mem = 32'h1 << ADDR_W;
    // size bit picks 4KB sector or 64KB block unit
    unit = n[`FSR_B_KBL] ? 32'h1000 : 32'h10000; // R14
    case (k)
      fsr_pkg::K_PP: span = 32'h100;
      fsr_pkg::K_SE: span = 32'h1000;
      fsr_pkg::K_HBE: span = 32'h8000;
      default: span = 32'h10000;
    endcase
    tlo = {8'h00, a} & (mem - 32'h1) & ~(span - 32'h1);
    thi = tlo + span - 32'h1;
    // block protect field grows the region in powers of two
    if (n[4:2] == 3'h0) begin
      sz = 32'h0;
    end else begin
      sz = unit << (32'(n[4:2]) - 32'h1);
    end
    if (sz > mem) begin
      sz = mem;
    end
    // top/bottom bit places the region
    lo = n[`FSR_B_SIDE] ? 32'h0 : mem - sz; // R14
    hi = n[`FSR_B_SIDE] ? sz - 32'h1 : mem - 32'h1;
    hit = (sz != 32'h0) && (tlo <= hi) && (thi >= lo); // R11
    // complement protects everything outside the region
    if (o[`FSR_B_COMPL]) begin
      hit = (sz == 32'h0) || (tlo < lo) || (thi > hi); // R19
    end
    // boot lock pins the selected unit at its end
    blo = n[`FSR_B_SIDE] ? 32'h0 : mem - unit;
    if (o[`FSR_B_BOOT] && (tlo <= blo + unit - 32'h1) && (thi >= blo)) begin
      hit = 1'b1; // R16
    end
    // otp mode targets the security pages
    if (otpm) begin
      case (a[13:12])
        2'h0: hit = o[`FSR_B_LOCK0]; // R15
        2'h1: hit = o[`FSR_B_LOCK1]; // R15
        2'h2: hit = o[`FSR_B_LOCK2]; // R15
        default: hit = 1'b1;
      endcase
    end
    return hit;
  endfunction

  // ----------------------------------------
  // status images
  // ----------------------------------------
  logic [7:0] sr_live; // status byte as read now
  logic hw_prot; // hardware protected mode
  logic sck_rise; // serial clock rising
  logic sck_fall; // serial clock falling
  logic cs_rise; // select released
  logic [2:0] step; // bits per edge

  always_comb begin
    // otp layout or normal layout, busy always in bit 0
    if (s.otp) begin
      sr_live = s.otpb & `FSR_OTP_MASK; // R8
    end else begin
      sr_live = {s.nv[7:2], s.wr_latch, 1'b0}; // R7
    end
    sr_live[`FSR_B_BUSY] = s.busy; // R9
  end

  // wp is dq2 only in single mode and only while pins are enabled
  assign hw_prot = s.nv[`FSR_B_PROT] & ~dq[2] & ~s.quad & ~s.otpb[`FSR_B_PINOFF]; // R13 R17
  assign sck_rise = sck & ~s.prev_sck;
  assign sck_fall = ~sck & s.prev_sck;
  assign cs_rise = cs_n & ~s.prev_cs_n;
  assign step = s.quad ? 3'h4 : 3'h1; // R21

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.prev_sck = sck;
    next_s.prev_cs_n = cs_n;
    next_s.req.valid = 1'b0;
    // write cycle timer and array completion end the busy time
    if (s.busy) begin
      if (s.st_wr) begin
        if (s.tmr == 16'h0) begin
          next_s.busy = 1'b0; // R9
          next_s.wr_latch = 1'b0; // R3
        end else begin
          next_s.tmr = s.tmr - 16'h1;
        end
      end else if (ARRAY_DONE) begin
        next_s.busy = 1'b0; // R9
        next_s.wr_latch = 1'b0; // R3
      end
    end
    if (cs_n) begin
      // deselected: release the lines, run a finished instruction
      next_s.phase = fsr_pkg::PH_IDLE;
      next_s.dq_oe = 4'h0;
      next_s.cnt = 5'h0;
      next_s.extra = 1'b0;
      if (cs_rise && !s.extra &&
          (s.phase == fsr_pkg::PH_DONE || s.phase == fsr_pkg::PH_PAGE)) begin
        case (s.opc)
          `FSR_OP_LATCH_ON: begin
            if (!s.busy) begin
              next_s.wr_latch = 1'b1; // R22
            end
          end
          `FSR_OP_LATCH_OFF: begin
            // leaving otp mode takes priority over the latch
            if (s.otp) begin
              next_s.otp = 1'b0; // R1
            end else begin
              next_s.wr_latch = 1'b0; // R1
            end
          end
          `FSR_OP_QPI: begin
            next_s.quad = 1'b1; // R18 R21
          end
          `FSR_OP_QRST: begin
            next_s.quad = 1'b0;
          end
          `FSR_OP_OTP: begin
            next_s.otp = 1'b1;
          end
          `FSR_OP_STAT_WR: begin
            // refused without latch, while busy, or when locked by wp
            if (s.wr_latch && !s.busy && !hw_prot) begin // R10 R13
              if (s.otp) begin
                next_s.otpb = s.otpb | (s.data & `FSR_OTP_MASK); // R15
              end else begin
                next_s.nv = s.data & `FSR_NV_MASK;
                if (s.otpb[`FSR_B_BOOT]) begin
                  next_s.nv[`FSR_B_KBL] = s.nv[`FSR_B_KBL]; // R16
                  next_s.nv[`FSR_B_SIDE] = s.nv[`FSR_B_SIDE]; // R16
                end
              end
              next_s.busy = 1'b1; // R9
              next_s.st_wr = 1'b1;
              next_s.tmr = 16'(TW_CYC);
            end
          end
          `FSR_OP_CE, `FSR_OP_CE2: begin
            if (s.wr_latch && !s.busy && s.nv[4:2] == 3'h0 && !s.otp &&
                !s.otpb[`FSR_B_BOOT]) begin // R10 R12
              next_s.req = '{1'b1, fsr_pkg::K_CE, 24'h0};
              next_s.busy = 1'b1;
              next_s.st_wr = 1'b0;
            end
          end
          default: begin
            // program and erase reach here after their address
            if (s.phase == fsr_pkg::PH_PAGE && s.wr_latch && !s.busy) begin // R10
              if (!blocked(s.req.kind, s.addr, s.nv, s.otpb, s.otp)) begin // R11
                next_s.req = '{1'b1, s.req.kind, s.addr};
                next_s.busy = 1'b1;
                next_s.st_wr = 1'b0;
              end
            end
          end
        endcase
      end
    end else if (sck_rise) begin
      // capture on the rising edge, msb first
      case (s.phase)
        fsr_pkg::PH_IDLE, fsr_pkg::PH_OPC: begin
          if (s.quad) begin
            next_s.opc = {s.opc[3:0], dq}; // R21 R24
          end else begin
            next_s.opc = {s.opc[6:0], dq[0]}; // R23 R24
          end
          next_s.cnt = s.cnt + 5'(step);
          next_s.phase = fsr_pkg::PH_OPC;
          if (s.cnt + 5'(step) == 5'd8) begin
            next_s.cnt = 5'h0;
            next_s.phase = fsr_pkg::PH_DONE;
            case (next_s.opc)
              `FSR_OP_STAT_RD: begin
                next_s.phase = fsr_pkg::PH_OUT;
                next_s.shout = sr_live; // R4
              end
              `FSR_OP_STAT3_RD: begin
                next_s.phase = fsr_pkg::PH_OUT;
                next_s.shout = s.sr3; // R20
              end
              `FSR_OP_STAT_WR: next_s.phase = fsr_pkg::PH_DATA;
              `FSR_OP_PP: begin
                next_s.phase = fsr_pkg::PH_ADDR;
                next_s.req.kind = fsr_pkg::K_PP;
              end
              `FSR_OP_SE: begin
                next_s.phase = fsr_pkg::PH_ADDR;
                next_s.req.kind = fsr_pkg::K_SE;
              end
              `FSR_OP_HBE: begin
                next_s.phase = fsr_pkg::PH_ADDR;
                next_s.req.kind = fsr_pkg::K_HBE;
              end
              `FSR_OP_BE: begin
                next_s.phase = fsr_pkg::PH_ADDR;
                next_s.req.kind = fsr_pkg::K_BE;
              end
              default: next_s.phase = fsr_pkg::PH_DONE;
            endcase
          end
        end
        fsr_pkg::PH_ADDR: begin
          if (s.quad) begin
            next_s.addr = {s.addr[19:0], dq};
          end else begin
            next_s.addr = {s.addr[22:0], dq[0]};
          end
          next_s.cnt = s.cnt + 5'(step);
          if (s.cnt + 5'(step) == 5'd24) begin
            next_s.cnt = 5'h0;
            next_s.phase = fsr_pkg::PH_PAGE;
          end
        end
        fsr_pkg::PH_DATA: begin
          if (s.quad) begin
            next_s.data = {s.data[3:0], dq};
          end else begin
            next_s.data = {s.data[6:0], dq[0]};
          end
          next_s.cnt = s.cnt + 5'(step);
          if (s.cnt + 5'(step) == 5'd8) begin
            next_s.cnt = 5'h0;
            next_s.phase = fsr_pkg::PH_DONE;
          end
        end
        fsr_pkg::PH_PAGE: begin
          // page data bits are not captured here; erases take none
          if (s.req.kind != fsr_pkg::K_PP) begin
            next_s.extra = 1'b1; // R2
          end
        end
        fsr_pkg::PH_DONE: begin
          // any bit past the last one cancels the instruction
          next_s.extra = 1'b1; // R2
        end
        fsr_pkg::PH_OUT: begin
          next_s.extra = 1'b0;
        end
        default: next_s.phase = fsr_pkg::PH_IDLE;
      endcase
    end else if (sck_fall && s.phase == fsr_pkg::PH_OUT) begin
      // shift out on the falling edge, reload after each byte
      if (s.quad) begin
        next_s.dq_out = s.shout[7:4]; // R21 R24
        next_s.dq_oe = 4'hf;
        next_s.shout = {s.shout[3:0], 4'h0};
      end else begin
        next_s.dq_out = {2'b00, s.shout[7], 1'b0}; // R23 R24
        next_s.dq_oe = 4'h2;
        next_s.shout = {s.shout[6:0], 1'b0};
      end
      next_s.cnt = s.cnt + 5'(step);
      if (s.cnt + 5'(step) == 5'd8) begin
        next_s.cnt = 5'h0;
        next_s.shout = (s.opc == `FSR_OP_STAT3_RD) ? s.sr3 : sr_live; // R5 R20
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      s <= '0; // latch, busy, modes cleared at power-up
      s.nv <= `FSR_SR_RESET; // R14 R19
      s.sr3 <= `FSR_SR3_RESET;
      s.prev_cs_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign DQ_OUT = s.dq_out;
  assign DQ_OE = s.dq_oe;
  assign ARRAY_REQ = s.req.valid ? s.req : '0;
  assign STATUS_BYTE = sr_live;
  assign QUAD_MODE = s.quad;

endmodule

`default_nettype wire

// File: test/fsr_core_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// port checks of the status block
// ------------------------------
module fsr_props #(
  parameter int TW_CYC = 5
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // link pins
  input wire logic SPI_SCK,
  input wire logic SPI_CS_N,
  input wire logic [3:0] DQ_IN,
  input wire logic [3:0] DQ_OUT,
  input wire logic [3:0] DQ_OE,
  // array side and status
  input wire fsr_pkg::fsr_op_t ARRAY_REQ,
  input wire logic ARRAY_DONE,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic QUAD_MODE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  logic [15:0] blen; // consecutive busy cycles

  // count the length of each busy period
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      blen <= 16'h0000;
    end else begin
      blen <= STATUS_BYTE[0] ? blen + 16'h0001 : 16'h0000;
    end
  end

  // array request and its completion
  sequence s_go;
    ARRAY_REQ.valid;
  endsequence
  sequence s_done;
    STATUS_BYTE[0] && ARRAY_DONE;
  endsequence

  property p_pulse;
    s_go |=> !ARRAY_REQ.valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("request longer than one cycle");
  property p_quiet;
    !ARRAY_REQ.valid |-> ARRAY_REQ == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("request fields not zero");
  property p_go_wel;
    s_go |-> $past(STATUS_BYTE[1:0]) == 2'b10;
  endproperty
  a_go_wel: assert property (p_go_wel) else $error("request without latch");
  property p_ce_free;
    ARRAY_REQ.valid && ARRAY_REQ.kind == fsr_pkg::K_CE |-> $past(STATUS_BYTE[4:2]) == 3'b000;
  endproperty
  a_ce_free: assert property (p_ce_free) else $error("chip erase while protected");
  property p_go_busy;
    s_go |=> STATUS_BYTE[0];
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("busy not set");
  property p_done;
    s_done |=> STATUS_BYTE[1:0] == 2'b00;
  endproperty
  a_done: assert property (p_done) else $error("busy or latch left after done");
  property p_tw_len;
    $fell(STATUS_BYTE[0]) && !$past(ARRAY_DONE) |-> blen == TW_CYC + 1;
  endproperty
  a_tw_len: assert property (p_tw_len) else $error("write cycle length wrong");
  property p_lanes;
    DQ_OE != 4'h0 |-> DQ_OE == (QUAD_MODE ? 4'hf : 4'h2);
  endproperty
  a_lanes: assert property (p_lanes) else $error("wrong output lanes");
  property p_oe_off;
    SPI_CS_N [*6] |-> DQ_OE == 4'h0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving while deselected");
  property p_hold;
    SPI_SCK [*6] |-> $stable(DQ_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while clock high");
endmodule

bind fsr_core fsr_props #(.TW_CYC(TW_CYC)) chk_u (.CLK_SYS(CLK_SYS), .NRST(NRST),
  .SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
  .ARRAY_REQ(ARRAY_REQ), .ARRAY_DONE(ARRAY_DONE), .STATUS_BYTE(STATUS_BYTE),
  .QUAD_MODE(QUAD_MODE));

`default_nettype wire

// File: test/fsr_host.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------
// host controller on the serial link
// ------------------------------
module fsr_host (
  // link pins
  output var logic SPI_SCK,
  output var logic SPI_CS_N,
  output var logic [3:0] DQ_IN,
  // data back
  input wire logic [3:0] DQ_OUT
);
  logic quad = 1'b0; // nibble lanes after quad enable
  logic wp_n = 1'b1; // write-protect level in single mode
  logic [7:0] rxq[$]; // bytes returned in the last frame

  // idle link, clock stands low
  initial begin
    SPI_SCK = 1'b0;
    SPI_CS_N = 1'b1;
    DQ_IN = 4'hf;
  end

  // one select period, bytes msb first, then deselect
  task automatic frame(input logic [7:0] tx[$]);
    logic [7:0] rx;
    rxq = {};
    #62.5 SPI_CS_N = 1'b0;
    foreach (tx[k]) begin
      for (int i = 7; i >= 0; i -= quad ? 4 : 1) begin
        // data set while clock low, taken on the rise
        if (quad) begin
          DQ_IN = tx[k][i -: 4];
        end else begin
          DQ_IN = {1'b1, wp_n, 1'b1, tx[k][i]};
        end
        #62.5 SPI_SCK = 1'b1;
        if (quad) begin
          rx[i -: 4] = DQ_OUT;
        end else begin
          rx[i] = DQ_OUT[1];
        end
        #62.5 SPI_SCK = 1'b0;
      end
      rxq.push_back(rx);
    end
    #62.5 SPI_CS_N = 1'b1;
    // released line no longer shows the last bit
    DQ_IN[0] = ~DQ_IN[0];
    #62.5;
  endtask
endmodule

`default_nettype wire

// File: test/test_flash_status_register_protection.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("FAIL %0t got %h want %h", $time, a, e); end end

// ------------------------------
// bench of the status block
// ------------------------------
module test_flash_status_register_protection;
  localparam int TW = 400; // shortened status write cycle
  logic CLK_SYS = 1'b0;
  logic NRST = 1'b0;
  logic ARRAY_DONE = 1'b0;
  logic SPI_SCK, SPI_CS_N, QUAD_MODE;
  logic [3:0] DQ_IN, DQ_OUT, DQ_OE;
  logic [7:0] STATUS_BYTE;
  fsr_pkg::fsr_op_t ARRAY_REQ;
  fsr_pkg::fsr_op_t last_req = '0; // last request taken
  logic [3:0] done_sr = 4'h0; // request to done delay
  int mismatches = 0;
  int checked = 0;
  int cyc = 0; // cycles run
  int blen = 0; // busy cycles so far
  int blast = 0; // length of last busy period

  fsr_core #(.ADDR_W(21), .TW_CYC(TW)) dut_u (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT),
    .DQ_OE(DQ_OE), .ARRAY_REQ(ARRAY_REQ), .ARRAY_DONE(ARRAY_DONE),
    .STATUS_BYTE(STATUS_BYTE), .QUAD_MODE(QUAD_MODE));
  fsr_host host_u (.SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT));

  // system clock
  initial begin
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // array engine, busy length, timeout
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    done_sr <= {done_sr[2:0], ARRAY_REQ.valid};
    ARRAY_DONE <= done_sr[3];
    if (ARRAY_REQ.valid === 1'b1) begin
      last_req <= ARRAY_REQ;
    end
    blen <= (STATUS_BYTE[0] === 1'b1) ? blen + 1 : 0;
    if (STATUS_BYTE[0] !== 1'b1 && blen != 0) begin
      blast <= blen;
    end
    if (cyc == 40000) begin
      mismatches++;
      conclude();
    end
  end

  // verdict
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // bounded wait until busy clears
  task automatic idle();
    repeat (8) @(posedge CLK_SYS);
    for (int n = 0; n < 2000 && STATUS_BYTE[0] !== 1'b0; n++) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
  endtask

  // lone opcode
  task automatic cmd(input logic [7:0] op);
    host_u.frame({op});
    idle();
  endtask

  // enable then status write
  task automatic wr(input logic [7:0] d);
    cmd(8'h06);
    host_u.frame({8'h01, d});
  endtask

  // read twice under one select, masked compare
  task automatic rd(input logic [7:0] op, input logic [7:0] m, input logic [7:0] e);
    host_u.frame({op, 8'h5a, 8'ha5});
    `CHK(host_u.rxq[1] & m, e)
    `CHK(host_u.rxq[2] & m, e)
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge CLK_SYS);
    NRST <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    `CHK(STATUS_BYTE, 8'h00)
    `CHK(QUAD_MODE, 1'b0)
    rd(8'h05, 8'hff, 8'h00);
    cmd(8'h06);
    `CHK(STATUS_BYTE, 8'h02)
    rd(8'h05, 8'hff, 8'h02);
    cmd(8'h04);
    `CHK(STATUS_BYTE, 8'h00)
    host_u.frame({8'h01, 8'h1c});
    idle();
    `CHK(STATUS_BYTE, 8'h00)
    $display("test latch done");
    wr(8'h1c);
    rd(8'h05, 8'h03, 8'h03);
    idle();
    `CHK(blast, TW + 1)
    `CHK(STATUS_BYTE, 8'h1c)
    cmd(8'h06);
    host_u.frame({8'h20, 8'h00, 8'h00, 8'h00});
    idle();
    host_u.frame({8'hc7});
    idle();
    `CHK(last_req.valid, 1'b0)
    `CHK(STATUS_BYTE, 8'h1e)
    wr(8'h00);
    idle();
    cmd(8'h06);
    host_u.frame({8'hc7});
    idle();
    `CHK(last_req.kind, fsr_pkg::K_CE)
    `CHK(STATUS_BYTE, 8'h00)
    cmd(8'h06);
    host_u.frame({8'h20, 8'h01, 8'h20, 8'h00});
    idle();
    `CHK(last_req.kind, fsr_pkg::K_SE)
    `CHK(last_req.addr, 24'h012000)
    $display("test protect done");
    wr(8'h80);
    idle();
    host_u.wp_n = 1'b0;
    wr(8'h9c);
    idle();
    `CHK(STATUS_BYTE, 8'h82)
    host_u.wp_n = 1'b1;
    host_u.frame({8'h01, 8'h00});
    idle();
    `CHK(STATUS_BYTE, 8'h00)
    cmd(8'h3a);
    wr(8'hd0);
    idle();
    `CHK(STATUS_BYTE, 8'hd0)
    wr(8'h00);
    idle();
    `CHK(STATUS_BYTE, 8'hd0)
    cmd(8'h04);
    `CHK(STATUS_BYTE, 8'h00)
    host_u.wp_n = 1'b0;
    wr(8'h80);
    idle();
    wr(8'h00);
    idle();
    `CHK(STATUS_BYTE, 8'h00)
    host_u.wp_n = 1'b1;
    cmd(8'h06);
    host_u.frame({8'h20, 8'h01, 8'h20, 8'h00});
    idle();
    `CHK(STATUS_BYTE, 8'h02)
    cmd(8'h04);
    $display("test lock done");
    rd(8'h95, 8'hff, 8'h00);
    cmd(8'h38);
    `CHK(QUAD_MODE, 1'b1)
    host_u.quad = 1'b1;
    cmd(8'h06);
    rd(8'h05, 8'hff, 8'h02);
    cmd(8'hff);
    `CHK(QUAD_MODE, 1'b0)
    host_u.quad = 1'b0;
    rd(8'h05, 8'hff, 8'h02);
    $display("test quad done");
    conclude();
  end
endmodule

`default_nettype wire
